//--- rtl/arit_pkg.sv
// package of constants for the auto-reload interval timer
package arit_pkg;
  localparam logic [7:0] ARIT_ADDR_CTRL = 8'hC8;
  localparam logic [7:0] ARIT_ADDR_RELOAD_LO = 8'hCA;
  localparam logic [7:0] ARIT_ADDR_RELOAD_HI = 8'hCB;
  localparam logic [7:0] ARIT_ADDR_IRQ_STAT = 8'hCC;
  localparam logic [7:0] ARIT_ADDR_IRQ_MASK = 8'hCD;
  localparam logic [7:0] ARIT_ADDR_COUNT_LO = 8'hCE;
  localparam logic [7:0] ARIT_ADDR_COUNT_HI = 8'hCF;
  localparam int ARIT_BIT_OVF = 7;
  localparam int ARIT_BIT_RUN = 2;
  localparam int ARIT_BIT_IRQ_OVF = 0;
  localparam logic [7:0] ARIT_RELOAD_RST = 8'h00;
  localparam logic [15:0] ARIT_COUNT_RST = 16'h0000;
  localparam logic [7:0] ARIT_MASK_RST = 8'h00;
  localparam int ARIT_OSC_PER_TICK = 2;
  localparam int ARIT_PRESCALE_W = 1;
  localparam logic [ARIT_PRESCALE_W-1:0] ARIT_PRESCALE_LAST = 1'h1;
endpackage : arit_pkg

//--- rtl/arit_regbus_if.sv
// interface carrying the register access strobes between timer parts
`timescale 1ns/1ps
`default_nettype none
interface arit_regbus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  modport master (output addr, output wdata, output wr, output rd);
  modport slave (input addr, input wdata, input wr, input rd);
endinterface : arit_regbus_if
`default_nettype wire

//--- rtl/arit_prescaler.sv
// prescaler giving one count tick every two oscillator periods
`timescale 1ns/1ps
`default_nettype none
module arit_prescaler
  import arit_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic run,
  output logic tick
);
  logic [ARIT_PRESCALE_W-1:0] div_r;
  logic [ARIT_PRESCALE_W-1:0] div_nxt;

  always_comb begin
    div_nxt = div_r;
    if (run) begin
      div_nxt = div_r + 1'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign tick = run && (div_r == ARIT_PRESCALE_LAST);
endmodule : arit_prescaler
`default_nettype wire

//--- rtl/arit_timer.sv
// auto-reload interval timer with register port and interrupt
// Summary of operation
// - 16-bit up-counter restarts from programmed reload value on overflow
// - no capture, baud or event counting; counts oscillator time only
// - counter steps every two clocks; period (65536-reload) times two clocks
// - control bit 7 set on overflow, cleared only by software writing zero
// - control bit 2 runs counter when one, holds count when zero
// - reload high byte register at 0xCB, resets to zero
// - reload low byte register at 0xCA, resets to zero
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module arit_timer
  import arit_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic ovf_irq_req,
  output logic irq
);
  arit_regbus_if bus ();

  assign bus.addr = reg_addr;
  assign bus.wdata = reg_wdata;
  assign bus.wr = reg_wr;
  assign bus.rd = reg_rd;

  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [7:0] reload_lo_r;
  logic [7:0] reload_lo_nxt;
  logic [7:0] reload_hi_r;
  logic [7:0] reload_hi_nxt;
  logic ovf_r;
  logic ovf_nxt;
  logic run_r;
  logic run_nxt;
  logic ovf_sticky_r;
  logic ovf_sticky_nxt;
  logic mask_r;
  logic mask_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic tick;
  logic wrap;
  logic count_lo_wr;
  logic count_hi_wr;
  logic reload_wr;

  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] o);
    wr_hit = wr && (a == o);
  endfunction : wr_hit

  // only the oscillator-derived tick advances the count
  arit_prescaler u_presc (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .run(run_r),
    .tick(tick)
  );

  assign wrap = tick && (count_r == 16'hFFFF);
  assign count_lo_wr = wr_hit(bus.wr, bus.addr, ARIT_ADDR_COUNT_LO);
  assign count_hi_wr = wr_hit(bus.wr, bus.addr, ARIT_ADDR_COUNT_HI);
  assign reload_wr = wr_hit(bus.wr, bus.addr, ARIT_ADDR_RELOAD_LO)
    || wr_hit(bus.wr, bus.addr, ARIT_ADDR_RELOAD_HI);

  always_comb begin
    count_nxt = count_r;
    if (wrap) begin
      count_nxt = {reload_hi_r, reload_lo_r};
    end else if (tick) begin
      count_nxt = count_r + 16'h0001;
    end
    // software preload wins over a same-cycle step; spares a full count from zero
    if (count_lo_wr) begin
      count_nxt[7:0] = bus.wdata;
    end
    if (count_hi_wr) begin
      count_nxt[15:8] = bus.wdata;
    end
  end

  always_comb begin
    reload_lo_nxt = reload_lo_r;
    reload_hi_nxt = reload_hi_r;
    run_nxt = run_r;
    mask_nxt = mask_r;
    if (wr_hit(bus.wr, bus.addr, ARIT_ADDR_RELOAD_LO)) begin
      reload_lo_nxt = bus.wdata;
    end
    if (wr_hit(bus.wr, bus.addr, ARIT_ADDR_RELOAD_HI)) begin
      reload_hi_nxt = bus.wdata;
    end
    if (wr_hit(bus.wr, bus.addr, ARIT_ADDR_CTRL)) begin
      run_nxt = bus.wdata[ARIT_BIT_RUN];
    end
    if (wr_hit(bus.wr, bus.addr, ARIT_ADDR_IRQ_MASK)) begin
      mask_nxt = bus.wdata[ARIT_BIT_IRQ_OVF];
    end
  end

  always_comb begin
    ovf_nxt = ovf_r;
    // software may only clear; writing one leaves the flag as is
    if (wr_hit(bus.wr, bus.addr, ARIT_ADDR_CTRL) && !bus.wdata[ARIT_BIT_OVF]) begin
      ovf_nxt = 1'b0;
    end
    if (wrap) begin
      ovf_nxt = 1'b1;
    end
  end

  always_comb begin
    ovf_sticky_nxt = ovf_sticky_r;
    if (wr_hit(bus.wr, bus.addr, ARIT_ADDR_IRQ_STAT) && bus.wdata[ARIT_BIT_IRQ_OVF]) begin
      ovf_sticky_nxt = 1'b0;
    end
    if (wrap) begin
      ovf_sticky_nxt = 1'b1;
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        ARIT_ADDR_CTRL: begin
          rdata_nxt[ARIT_BIT_OVF] = ovf_r;
          rdata_nxt[ARIT_BIT_RUN] = run_r;
        end
        ARIT_ADDR_RELOAD_LO: rdata_nxt = reload_lo_r;
        ARIT_ADDR_RELOAD_HI: rdata_nxt = reload_hi_r;
        ARIT_ADDR_IRQ_STAT: rdata_nxt[ARIT_BIT_IRQ_OVF] = ovf_sticky_r;
        ARIT_ADDR_IRQ_MASK: rdata_nxt[ARIT_BIT_IRQ_OVF] = mask_r;
        ARIT_ADDR_COUNT_LO: rdata_nxt = count_r[7:0];
        ARIT_ADDR_COUNT_HI: rdata_nxt = count_r[15:8];
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_r <= ARIT_COUNT_RST;
      reload_lo_r <= ARIT_RELOAD_RST;
      reload_hi_r <= ARIT_RELOAD_RST;
      ovf_r <= 1'b0;
      run_r <= 1'b0;
      ovf_sticky_r <= 1'b0;
      mask_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      count_r <= count_nxt;
      reload_lo_r <= reload_lo_nxt;
      reload_hi_r <= reload_hi_nxt;
      ovf_r <= ovf_nxt;
      run_r <= run_nxt;
      ovf_sticky_r <= ovf_sticky_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign ovf_irq_req = ovf_r;
  assign irq = ovf_sticky_r && mask_r;

  // helper: cycles since the last overflow, for the period check; a period
  // only counts when run, count and reload were left alone since the wrap
  logic [16:0] gap_r;
  logic [16:0] gap_nxt;
  logic seen_r;
  logic seen_nxt;

  always_comb begin
    gap_nxt = gap_r + 17'h00001;
    seen_nxt = seen_r;
    if (wrap || !run_r) begin
      gap_nxt = 17'h00000;
    end
    if (!run_r || count_lo_wr || count_hi_wr || reload_wr) begin
      seen_nxt = 1'b0;
    end else if (wrap) begin
      seen_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gap_r <= 17'h00000;
      seen_r <= 1'b0;
    end else begin
      gap_r <= gap_nxt;
      seen_r <= seen_nxt;
    end
  end

  reload_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wrap && !count_lo_wr && !count_hi_wr)
    |=> count_r == $past({reload_hi_r, reload_lo_r}))
    else $error("count not reloaded after overflow");

  step_rate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (run_r && !wrap && !count_lo_wr && !count_hi_wr)
    |=> (count_r == $past(count_r) || count_r == $past(count_r) + 16'h0001))
    else $error("count moved by more than one");

  tick_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (tick && !wrap && !count_lo_wr && !count_hi_wr)
    |=> count_r == $past(count_r) + 16'h0001)
    else $error("count did not step on tick");

  two_clock_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tick
    |=> !tick)
    else $error("tick on consecutive clocks");

  period_len_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wrap && seen_r && $stable({reload_hi_r, reload_lo_r}) && run_r)
    |-> gap_r == 17'((17'h10000 - {1'b0, reload_hi_r, reload_lo_r}) * 2 - 1))
    else $error("overflow period wrong");

  flag_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wrap
    |=> ovf_r && ovf_sticky_r)
    else $error("overflow flag not set");

  flag_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ovf_r && !(reg_wr && reg_addr == ARIT_ADDR_CTRL && !reg_wdata[ARIT_BIT_OVF]))
    |=> ovf_r)
    else $error("overflow flag lost without clear");

  flag_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_hit(reg_wr, reg_addr, ARIT_ADDR_CTRL) && !reg_wdata[ARIT_BIT_OVF] && !wrap)
    |=> !ovf_r)
    else $error("overflow flag not cleared by write");

  run_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!run_r && !count_lo_wr && !count_hi_wr)
    |=> $stable(count_r))
    else $error("count moved while halted");

  run_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_hit(reg_wr, reg_addr, ARIT_ADDR_CTRL)
    |=> run_r == $past(reg_wdata[ARIT_BIT_RUN]))
    else $error("run control not written");

  ctrl_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && reg_addr == ARIT_ADDR_CTRL)
    |=> reg_rdata == {$past(ovf_r), 4'h0, $past(run_r), 2'h0})
    else $error("control readback wrong");

  reload_reg_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && reg_addr == ARIT_ADDR_RELOAD_HI)
    |=> reload_hi_r == $past(reg_wdata))
    else $error("reload high not written");

  reload_hi_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && reg_addr == ARIT_ADDR_RELOAD_HI)
    |=> reg_rdata == $past(reload_hi_r))
    else $error("reload high readback wrong");

  reload_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_rd && reg_addr == ARIT_ADDR_RELOAD_LO)
    |=> reg_rdata == $past(reload_lo_r))
    else $error("reload low readback wrong");

  reload_lo_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reg_wr && reg_addr == ARIT_ADDR_RELOAD_LO)
    |=> reload_lo_r == $past(reg_wdata))
    else $error("reload low not written");

  irq_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(ovf_irq_req)
    |-> $past(wrap))
    else $error("overflow request without overflow");

  irq_raise_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ($past(wrap) && mask_r)
    |-> irq)
    else $error("interrupt not raised after overflow");

  sticky_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_hit(reg_wr, reg_addr, ARIT_ADDR_IRQ_STAT) && reg_wdata[ARIT_BIT_IRQ_OVF] && !wrap)
    |=> !ovf_sticky_r)
    else $error("status bit not cleared by write");

  count_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    count_hi_wr
    |=> count_r[15:8] == $past(reg_wdata))
    else $error("count high byte not written");

  rdata_idle_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !reg_rd
    |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read");
endmodule : arit_timer
`default_nettype wire

//--- verif/testbench.sv
// self-checking testbench for the auto-reload interval timer
`timescale 1ns/1ps
`default_nettype none
module testbench
  import arit_pkg::*;
;
  localparam logic [15:0] RLD = 16'hFFF0;
  localparam int PERIOD = (65536 - int'(RLD)) * ARIT_OSC_PER_TICK;
  localparam logic [15:0] PRE = 16'hFFF8;
  localparam int FIRST = (65536 - int'(PRE)) * ARIT_OSC_PER_TICK;
  localparam int LIMIT = 3000;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic ovf_irq_req;
  logic irq;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;

  arit_timer i_arit_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .ovf_irq_req(ovf_irq_req),
    .irq(irq)
  );

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic give_verdict;
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      give_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd_chk

  // waits for the overflow request to show, within a bounded number of cycles
  task automatic wait_flag(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n = n + 1;
    end while (ovf_irq_req !== 1'b1 && n < 200);
  endtask : wait_flag

  task automatic t_reset_and_reload;
    rd_chk(ARIT_ADDR_RELOAD_LO, 8'h00);
    rd_chk(ARIT_ADDR_RELOAD_HI, 8'h00);
    rd_chk(ARIT_ADDR_CTRL, 8'h00);
    rd_chk(8'h00, 8'h00);
    wr_reg(ARIT_ADDR_RELOAD_LO, RLD[7:0]);
    wr_reg(ARIT_ADDR_RELOAD_HI, RLD[15:8]);
    rd_chk(ARIT_ADDR_RELOAD_LO, RLD[7:0]);
    rd_chk(ARIT_ADDR_RELOAD_HI, RLD[15:8]);
  endtask : t_reset_and_reload

  task automatic t_first_overflow;
    int n;
    wr_reg(ARIT_ADDR_COUNT_HI, PRE[15:8]);
    wr_reg(ARIT_ADDR_COUNT_LO, PRE[7:0]);
    rd_chk(ARIT_ADDR_COUNT_LO, PRE[7:0]);
    wr_reg(ARIT_ADDR_CTRL, 8'h04);
    wait_flag(n);
    chk(8'(n), 8'(FIRST));
    chk({7'h00, ovf_irq_req}, 8'h01);
    chk({7'h00, irq}, 8'h00);
    rd_chk(ARIT_ADDR_CTRL, 8'h84);
    rd_chk(ARIT_ADDR_COUNT_HI, RLD[15:8]);
    // two ticks have passed since the reload when this read is taken
    rd_chk(ARIT_ADDR_COUNT_LO, RLD[7:0] + 8'h02);
  endtask : t_first_overflow

  task automatic t_period;
    int n;
    wr_reg(ARIT_ADDR_CTRL, 8'h04);
    wait_flag(n);
    wr_reg(ARIT_ADDR_CTRL, 8'h04);
    #1;
    chk({7'h00, ovf_irq_req}, 8'h00);
    wait_flag(n);
    // the clearing write took two of the edges between the overflows
    chk(8'(n + 2), 8'(PERIOD));
  endtask : t_period

  task automatic t_irq_and_hold;
    logic [7:0] lo;
    wr_reg(ARIT_ADDR_CTRL, 8'h84);
    #1;
    chk({7'h00, ovf_irq_req}, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr_reg(ARIT_ADDR_IRQ_MASK, 8'h01);
    @(posedge clk_sys);
    #1;
    chk({7'h00, irq}, 8'h01);
    wr_reg(ARIT_ADDR_CTRL, 8'h00);
    wr_reg(ARIT_ADDR_CTRL, 8'h00);
    rd_chk(ARIT_ADDR_CTRL, 8'h00);
    chk({7'h00, ovf_irq_req}, 8'h00);
    @(posedge clk_sys);
    reg_addr <= ARIT_ADDR_COUNT_LO;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    lo = reg_rdata;
    repeat (10) @(posedge clk_sys);
    rd_chk(ARIT_ADDR_COUNT_LO, lo);
    chk({7'h00, irq}, 8'h01);
    wr_reg(ARIT_ADDR_IRQ_STAT, 8'h01);
    @(posedge clk_sys);
    #1;
    chk({7'h00, irq}, 8'h00);
  endtask : t_irq_and_hold

  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset_and_reload();
    t_first_overflow();
    t_period();
    t_irq_and_hold();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
